// ### logic/pbs_params.svh
/*
  Constants of the peripheral bus sequencer and the peripheral unit end.
  Assumes a 10 MHz clock; included by bare name wherever needed.
*/
// Function
// - Unit name: type bits 7-11, member 0-6
// - Enable-address bit 12 is maintenance flag
// - Sync pulse before order clears inputs
// - Clock-start high/low on bits 15, 16
// - Write bits 0-28 data, 29-35 opcode
// - Bit 36 scope sync, bit 37 unused
// - Bits 38/39 odd parity odd/even bits
// - Reply data bits 0-23, parity bit 25
// - Reply bit 24 is all-seems-well always
// - Bit 26 F-level, 27 interject, 28 unused
// - Eight control pulses from control-pulse commands
// - Duplicate bus copies, selection set by device
// - Only matching unit name answers an order
// - Poll: each unit answers one bit
// - Separate sequencer runs access, signals completion
// - Stall dependent instruction until access completes
// - Access lasts 11 to 136 operating cycles
// - First two cycles load address, data registers
// - Address and order driven cycles 4-6
// - Complete on reply data or all-seems-well
// - Reply data loaded into reply register
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

`define PBS_CLK_PS 100000
`define PBS_OPCYC_PS 166670
`define PBS_SYNC_LEAD_NS 500
`define PBS_MIN_OPS 11
`define PBS_MAX_OPS 136
`define PBS_SETUP_OPS 2
`define PBS_PRES_FIRST_OP 4
`define PBS_PRES_LAST_OP 6
`define PBS_CDIV(a) (((a) + `PBS_CLK_PS - 1) / `PBS_CLK_PS)
`define PBS_SYNC_LEAD_CYC `PBS_CDIV(`PBS_SYNC_LEAD_NS * 1000)
`define PBS_SETUP_CYC `PBS_CDIV(`PBS_SETUP_OPS * `PBS_OPCYC_PS)
// Window edges round down so the window opens at the sync lead
`define PBS_FDIV(a) ((a) / `PBS_CLK_PS)
`define PBS_PRES_START_CYC \
  `PBS_FDIV((`PBS_PRES_FIRST_OP - 1) * `PBS_OPCYC_PS)
`define PBS_PRES_END_CYC `PBS_FDIV(`PBS_PRES_LAST_OP * `PBS_OPCYC_PS)
`define PBS_MIN_CYC `PBS_CDIV(`PBS_MIN_OPS * `PBS_OPCYC_PS)
`define PBS_MAX_CYC ((`PBS_MAX_OPS * `PBS_OPCYC_PS) / `PBS_CLK_PS)

`define PBS_REG_CTRL 4'h0
`define PBS_REG_UNIT 4'h1
`define PBS_REG_ORDER_LO 4'h2
`define PBS_REG_ORDER_HI 4'h3
`define PBS_REG_CMD 4'h4
`define PBS_REG_STATUS 4'h5
`define PBS_REG_REPLY 4'h6
`define PBS_REG_POLL 4'h7

`define PBS_CTRL_MAINT 0
`define PBS_CTRL_COPY 1
`define PBS_CMD_START 0
`define PBS_CMD_SCOPE 1
`define PBS_CMD_PULSE_LO 8
`define PBS_ST_BUSY 0
`define PBS_ST_DONE 1
`define PBS_ST_ASW 2
`define PBS_ST_TIMEOUT 3
`define PBS_ST_PARERR 4
`define PBS_ST_FLEVEL 5
`define PBS_ST_INJ 6

`define PBS_EA_MAINT 12
`define PBS_EA_CLK_HIGH 15
`define PBS_EA_CLK_LOW 16
`define PBS_W_SCOPE 36
`define PBS_W_PAR_ODD 38
`define PBS_W_PAR_EVEN 39
`define PBS_R_ASW 24
`define PBS_R_PAR 25
`define PBS_R_FLEVEL 26
`define PBS_R_INJ 27
`define PBS_ODD_MASK_E 12'hAAA
`define PBS_ODD_MASK_P 36'hA_AAAA_AAAA
`define PBS_EVEN_MASK_E 12'h555
`define PBS_EVEN_MASK_P 36'h5_5555_5555

`endif

// ### logic/pbs_pkg.sv
/*
  Types of the peripheral bus sequencer.
  Assumes pbs_params.svh for all numeric constants.
*/
package pbs_pkg;
  typedef enum logic {PBS_IDLE, PBS_ACCESS} pbs_state_e;
  typedef logic [7:0] pbs_count_t;
endpackage

// ### logic/pbs_bus_if.sv
/*
  Peripheral bus between the sequencer and peripheral unit frames.
  Assumes one clock shared by both ends; the bench joins them.
*/
`timescale 1ns/1ns
interface pbs_bus_if;
  logic [16:0] enable_address_bus;
  logic order_sync_pulse;
  logic [39:0] order_write_bus;
  logic [7:0] control_pulse_bus;
  logic bus_copy_select;
  logic [28:0] reply_bus;
  modport seq (
    output enable_address_bus, order_sync_pulse, order_write_bus,
    output control_pulse_bus, bus_copy_select,
    input reply_bus
  );
  modport unit (
    input enable_address_bus, order_sync_pulse, order_write_bus,
    input control_pulse_bus, bus_copy_select,
    output reply_bus
  );
endinterface

// ### logic/pbs_sequencer.sv
/*
  Peripheral sequencer: runs coded enable accesses and polls on the
  peripheral bus beside the execution sequencer.
  Assumes a word-addressed software port and one 10 MHz clock.
*/
`timescale 1ns/1ns
`include "pbs_params.svh"
module pbs_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Software register port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  // Execution sequencer side
  input wire logic exec_depends,
  output logic exec_stall,
  output logic access_done,
  output logic flevel_req,
  output logic interject_req,
  // Peripheral bus
  pbs_bus_if.seq bus
);
  pbs_pkg::pbs_state_e state_reg;
  pbs_pkg::pbs_count_t cnt_reg;
  logic maint_reg;
  logic copy_reg;
  logic [11:0] unit_reg;
  logic [35:0] order_reg;
  logic [11:0] e_reg;
  logic [35:0] p_reg;
  logic e_maint_reg;
  logic got_reg;
  logic done_reg;
  logic asw_reg;
  logic timeout_reg;
  logic parerr_reg;
  logic [23:0] reply_reg;
  logic [23:0] poll_reg;
  logic [1:0] poll_pend_reg;
  logic wr_cmd;
  logic accept;
  logic reply_now;
  logic finish;
  logic timeout_now;
  logic in_reply;
  logic pres;
  logic pres_first;
  logic pres_last;
  logic par_odd;
  logic par_even;
  logic [7:0] pulses;

  assign wr_cmd = sw_wr && sw_addr == `PBS_REG_CMD;
  assign accept = wr_cmd && sw_wdata[`PBS_CMD_START] &&
    state_reg == pbs_pkg::PBS_IDLE;
  assign pulses = sw_wdata[`PBS_CMD_PULSE_LO +: 8];
  assign in_reply = state_reg == pbs_pkg::PBS_ACCESS &&
    cnt_reg >= 8'(`PBS_PRES_END_CYC);
  // Data present: any data bit or its parity bit, or all-seems-well
  assign reply_now = in_reply && (bus.reply_bus[`PBS_R_ASW] ||
    (|{bus.reply_bus[`PBS_R_PAR], bus.reply_bus[23:0]}));
  assign finish = (got_reg || reply_now) &&
    cnt_reg >= 8'(`PBS_MIN_CYC - 1);
  assign timeout_now = state_reg == pbs_pkg::PBS_ACCESS && !got_reg &&
    !reply_now && cnt_reg == 8'(`PBS_MAX_CYC - 1);
  // Outputs are registered, so window tests lead by one count
  assign pres = state_reg == pbs_pkg::PBS_ACCESS &&
    cnt_reg >= 8'(`PBS_PRES_START_CYC - 1) &&
    cnt_reg < 8'(`PBS_PRES_END_CYC - 1);
  assign pres_first = pres && cnt_reg == 8'(`PBS_PRES_START_CYC - 1);
  assign pres_last = pres && cnt_reg == 8'(`PBS_PRES_END_CYC - 2);
  assign par_odd = ~^{e_reg & `PBS_ODD_MASK_E,
    p_reg & `PBS_ODD_MASK_P};
  assign par_even = ~^{e_reg & `PBS_EVEN_MASK_E,
    p_reg & `PBS_EVEN_MASK_P};

  // Software-written registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maint_reg <= 1'b0;
      copy_reg <= 1'b0;
      unit_reg <= 12'h000;
      order_reg <= 36'h0_0000_0000;
    end else if (sw_wr) begin
      case (sw_addr)
        `PBS_REG_CTRL: begin
          maint_reg <= sw_wdata[`PBS_CTRL_MAINT];
          copy_reg <= sw_wdata[`PBS_CTRL_COPY];
        end
        `PBS_REG_UNIT: unit_reg <= sw_wdata[11:0];
        `PBS_REG_ORDER_LO: order_reg[31:0] <= sw_wdata;
        `PBS_REG_ORDER_HI: order_reg[35:32] <= sw_wdata[3:0];
        default: ;
      endcase
    end
  end

  // Access sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pbs_pkg::PBS_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        pbs_pkg::PBS_IDLE: begin
          if (accept) begin
            state_reg <= pbs_pkg::PBS_ACCESS;
            cnt_reg <= 8'h00;
          end
        end
        pbs_pkg::PBS_ACCESS: begin
          cnt_reg <= cnt_reg + 8'h01;
          if (finish || timeout_now) begin
            state_reg <= pbs_pkg::PBS_IDLE;
          end
        end
        default: state_reg <= pbs_pkg::PBS_IDLE;
      endcase
    end
  end

  // Address and data registers loaded in the setup cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      e_reg <= 12'h000;
      p_reg <= 36'h0_0000_0000;
      e_maint_reg <= 1'b0;
    end else if (accept) begin
      e_reg <= unit_reg;
      p_reg <= order_reg;
      e_maint_reg <= maint_reg;
    end
  end

  // Reply capture and access result flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      got_reg <= 1'b0;
      done_reg <= 1'b0;
      asw_reg <= 1'b0;
      timeout_reg <= 1'b0;
      parerr_reg <= 1'b0;
      reply_reg <= 24'h00_0000;
    end else if (accept) begin
      got_reg <= 1'b0;
      done_reg <= 1'b0;
      asw_reg <= 1'b0;
      timeout_reg <= 1'b0;
      parerr_reg <= 1'b0;
    end else begin
      if (reply_now && !got_reg) begin
        got_reg <= 1'b1;
        reply_reg <= bus.reply_bus[23:0];
        asw_reg <= bus.reply_bus[`PBS_R_ASW];
        // Parity is only judged when data came back
        parerr_reg <= (|{bus.reply_bus[`PBS_R_PAR],
          bus.reply_bus[23:0]}) && ~^{bus.reply_bus[`PBS_R_PAR],
          bus.reply_bus[23:0]};
      end
      if (finish || timeout_now) begin
        done_reg <= 1'b1;
      end
      if (timeout_now) begin
        timeout_reg <= 1'b1;
      end
    end
  end

  // Peripheral bus drivers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.enable_address_bus <= 17'h0_0000;
      bus.order_write_bus <= 40'h00_0000_0000;
      bus.order_sync_pulse <= 1'b0;
      bus.control_pulse_bus <= 8'h00;
      bus.bus_copy_select <= 1'b0;
    end else begin
      // Sync lead equals the gap to the first present cycle
      bus.order_sync_pulse <= accept;
      bus.bus_copy_select <= copy_reg;
      bus.control_pulse_bus <= (wr_cmd &&
        state_reg == pbs_pkg::PBS_IDLE) ? pulses : 8'h00;
      bus.enable_address_bus <= 17'h0_0000;
      bus.order_write_bus <= 40'h00_0000_0000;
      bus.order_write_bus[`PBS_W_SCOPE] <= wr_cmd &&
        sw_wdata[`PBS_CMD_SCOPE];
      if (pres) begin
        bus.enable_address_bus[11:0] <= e_reg;
        bus.enable_address_bus[`PBS_EA_MAINT] <= e_maint_reg;
        bus.enable_address_bus[`PBS_EA_CLK_HIGH] <= pres_first;
        bus.enable_address_bus[`PBS_EA_CLK_LOW] <= pres_last;
        bus.order_write_bus[35:0] <= p_reg;
        bus.order_write_bus[`PBS_W_PAR_ODD] <= par_odd;
        bus.order_write_bus[`PBS_W_PAR_EVEN] <= par_even;
      end
    end
  end

  // Poll answers captured together two cycles after the command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_pend_reg <= 2'b00;
      poll_reg <= 24'h00_0000;
    end else begin
      poll_pend_reg <= {poll_pend_reg[0], wr_cmd && (|pulses) &&
        state_reg == pbs_pkg::PBS_IDLE};
      if (poll_pend_reg[1]) begin
        poll_reg <= bus.reply_bus[23:0];
      end
    end
  end

  // Execution sequencer signals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_stall <= 1'b0;
      access_done <= 1'b0;
      flevel_req <= 1'b0;
      interject_req <= 1'b0;
    end else begin
      exec_stall <= exec_depends && (accept ||
        (state_reg == pbs_pkg::PBS_ACCESS &&
        !(finish || timeout_now)));
      access_done <= finish || timeout_now;
      flevel_req <= bus.reply_bus[`PBS_R_FLEVEL];
      interject_req <= bus.reply_bus[`PBS_R_INJ];
    end
  end

  // Read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_rdata <= 32'h0000_0000;
    end else begin
      sw_rdata <= 32'h0000_0000;
      if (sw_rd) begin
        case (sw_addr)
          `PBS_REG_CTRL: begin
            sw_rdata[`PBS_CTRL_MAINT] <= maint_reg;
            sw_rdata[`PBS_CTRL_COPY] <= copy_reg;
          end
          `PBS_REG_UNIT: sw_rdata[11:0] <= unit_reg;
          `PBS_REG_ORDER_LO: sw_rdata <= order_reg[31:0];
          `PBS_REG_ORDER_HI: sw_rdata[3:0] <= order_reg[35:32];
          `PBS_REG_STATUS: begin
            sw_rdata[`PBS_ST_BUSY] <= state_reg == pbs_pkg::PBS_ACCESS;
            sw_rdata[`PBS_ST_DONE] <= done_reg;
            sw_rdata[`PBS_ST_ASW] <= asw_reg;
            sw_rdata[`PBS_ST_TIMEOUT] <= timeout_reg;
            sw_rdata[`PBS_ST_PARERR] <= parerr_reg;
            sw_rdata[`PBS_ST_FLEVEL] <= flevel_req;
            sw_rdata[`PBS_ST_INJ] <= interject_req;
          end
          `PBS_REG_REPLY: sw_rdata[23:0] <= reply_reg;
          `PBS_REG_POLL: sw_rdata[23:0] <= poll_reg;
          default: sw_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // pbs_sequencer

// ### logic/pbs_unit.sv
/*
  Peripheral unit end of the peripheral bus: order receiver, replier,
  poll responder and autonomous request source.
  Assumes the sequencer's framing and one shared clock.
*/
`timescale 1ns/1ns
`include "pbs_params.svh"
module pbs_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Unit identity and bus copy
  input wire logic [11:0] unit_name,
  input wire logic unit_copy,
  // Received order
  output logic order_valid,
  output logic [35:0] order_word,
  output logic order_maint,
  output logic order_parity_ok,
  // Reply
  input wire logic reply_go,
  input wire logic reply_with_data,
  input wire logic [23:0] reply_data,
  // Poll answer
  input wire logic [7:0] poll_mask,
  input wire logic [4:0] poll_slot,
  input wire logic poll_status,
  // Autonomous requests
  input wire logic flevel_in,
  input wire logic interject_in,
  // Peripheral bus
  pbs_bus_if.unit bus
);
  logic active;
  logic match;
  logic par_odd;
  logic par_even;
  logic [28:0] rep;

  assign active = bus.bus_copy_select == unit_copy;
  assign match = active && bus.enable_address_bus[`PBS_EA_CLK_HIGH] &&
    bus.enable_address_bus[11:0] == unit_name;
  assign par_odd = ~^{bus.enable_address_bus[11:0] & `PBS_ODD_MASK_E,
    bus.order_write_bus[35:0] & `PBS_ODD_MASK_P};
  assign par_even = ~^{bus.enable_address_bus[11:0] & `PBS_EVEN_MASK_E,
    bus.order_write_bus[35:0] & `PBS_EVEN_MASK_P};

  // Input register: cleared by sync, loaded on a matching order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      order_valid <= 1'b0;
      order_word <= 36'h0_0000_0000;
      order_maint <= 1'b0;
      order_parity_ok <= 1'b0;
    end else begin
      order_valid <= match;
      if (bus.order_sync_pulse) begin
        order_word <= 36'h0_0000_0000;
        order_maint <= 1'b0;
        order_parity_ok <= 1'b0;
      end else if (match) begin
        order_word <= bus.order_write_bus[35:0];
        order_maint <= bus.enable_address_bus[`PBS_EA_MAINT];
        order_parity_ok <= par_odd ==
          bus.order_write_bus[`PBS_W_PAR_ODD] && par_even ==
          bus.order_write_bus[`PBS_W_PAR_EVEN];
      end
    end
  end

  // Reply word assembly
  always_comb begin
    rep = 29'h0000_0000;
    rep[`PBS_R_FLEVEL] = flevel_in;
    rep[`PBS_R_INJ] = interject_in;
    if (active && reply_go) begin
      rep[`PBS_R_ASW] = 1'b1;
      if (reply_with_data) begin
        rep[23:0] = reply_data;
        rep[`PBS_R_PAR] = ~^reply_data;
      end
    end else if (active && |(bus.control_pulse_bus & poll_mask) &&
      poll_slot < 5'h18) begin
      rep[poll_slot] = poll_status;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.reply_bus <= 29'h0000_0000;
    end else begin
      bus.reply_bus <= rep;
    end
  end
endmodule // pbs_unit

// ### verification/pbs_bus_sva.sv
/*
  Checker of the peripheral bus between sequencer and unit ends.
  Assumes instantiation beside the interface, one clock, rst_n low.
*/
`timescale 1ns/1ns
`include "pbs_params.svh"
module pbs_bus_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus signals
  input wire logic [16:0] enable_address_bus,
  input wire logic order_sync_pulse,
  input wire logic [39:0] order_write_bus,
  input wire logic [7:0] control_pulse_bus,
  input wire logic bus_copy_select,
  input wire logic [28:0] reply_bus
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet;
    (enable_address_bus == 17'h0) [*4];
  endsequence
  sequence s_present;
    enable_address_bus[15] ##1 !enable_address_bus[15] [*3]
      ##1 enable_address_bus[16];
  endsequence
  a_sync_then_present: assert property (
    order_sync_pulse |=> s_quiet ##1 s_present)
    else $error("present window not five cycles after sync");
  a_name_held: assert property (
    enable_address_bus[15] |=> $stable(enable_address_bus[12:0]) [*4])
    else $error("unit name moved in present window");
  a_order_held: assert property (
    enable_address_bus[15] |=> $stable(order_write_bus[35:0]) [*4])
    else $error("order word moved in present window");
  a_parity_odd_bits: assert property (
    enable_address_bus[15] |-> order_write_bus[38] ==
      ~^{enable_address_bus[11:0] & `PBS_ODD_MASK_E,
         order_write_bus[35:0] & `PBS_ODD_MASK_P})
    else $error("odd-bit parity wrong");
  a_parity_even_bits: assert property (
    enable_address_bus[15] |-> order_write_bus[39] ==
      ~^{enable_address_bus[11:0] & `PBS_EVEN_MASK_E,
         order_write_bus[35:0] & `PBS_EVEN_MASK_P})
    else $error("even-bit parity wrong");
  a_spare_bits_low: assert property (
    order_write_bus[37] == 1'h0 && enable_address_bus[14:13] == 2'h0)
    else $error("spare bus bit driven");
  a_pulse_single: assert property (
    |control_pulse_bus |=> control_pulse_bus == 8'h0)
    else $error("control pulse longer than one cycle");
  a_sync_single: assert property (
    order_sync_pulse |=> !order_sync_pulse)
    else $error("sync pulse longer than one cycle");
endmodule // pbs_bus_sva

// ### verification/test_peripheral_bus_sequencer.sv
/*
  Self-checking bench joining sequencer and unit over the bus.
  Assumes the design files under logic/ and a 10 MHz clock.
*/
`timescale 1ns/1ns
`include "pbs_params.svh"
module test_peripheral_bus_sequencer;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'h0;
  logic sw_rd = 1'h0;
  logic [31:0] sw_rdata;
  logic exec_depends = 1'h1;
  logic exec_stall, access_done, flevel_req, interject_req;
  logic [11:0] unit_name = 12'h2C5;
  logic unit_copy = 1'h0;
  logic order_valid, order_maint, order_parity_ok;
  logic [35:0] order_word;
  logic reply_go = 1'h0;
  logic reply_with_data = 1'h1;
  logic [23:0] reply_data = 24'hA5C3F0;
  logic [7:0] poll_mask = 8'h0;
  logic [4:0] poll_slot = 5'h0;
  logic poll_status = 1'h0;
  logic flevel_in = 1'h0;
  logic interject_in = 1'h0;
  logic [35:0] ord = 36'h9_5A3C_0F71;
  int error_cnt = 0;
  int comparisons = 0;

  always #50 clk = ~clk;

  pbs_bus_if bus ();
  pbs_sequencer u_pbs_sequencer (.clk(clk), .rst_n(rst_n),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .exec_depends(exec_depends),
    .exec_stall(exec_stall), .access_done(access_done),
    .flevel_req(flevel_req), .interject_req(interject_req), .bus(bus));
  pbs_unit u_pbs_unit (.clk(clk), .rst_n(rst_n), .unit_name(unit_name),
    .unit_copy(unit_copy), .order_valid(order_valid),
    .order_word(order_word), .order_maint(order_maint),
    .order_parity_ok(order_parity_ok), .reply_go(reply_go),
    .reply_with_data(reply_with_data), .reply_data(reply_data),
    .poll_mask(poll_mask), .poll_slot(poll_slot),
    .poll_status(poll_status), .flevel_in(flevel_in),
    .interject_in(interject_in), .bus(bus));
  pbs_bus_sva u_pbs_bus_sva (.clk(clk), .rst_n(rst_n),
    .enable_address_bus(bus.enable_address_bus),
    .order_sync_pulse(bus.order_sync_pulse),
    .order_write_bus(bus.order_write_bus),
    .control_pulse_bus(bus.control_pulse_bus),
    .bus_copy_select(bus.bus_copy_select), .reply_bus(bus.reply_bus));

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_wr <= 1'h1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_rd <= 1'h1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'h0;
    #1;
    d = sw_rdata;
  endtask

  // One coded access; name or copy mismatch leaves the order unreceived
  task automatic access(input logic [11:0] nm, input logic mt,
                        input logic cp, input logic rep);
    logic [31:0] d;
    logic seen;
    int i;
    wr(4'h0, {30'h0, cp, mt});
    wr(4'h1, {20'h0, nm});
    wr(4'h2, ord[31:0]);
    wr(4'h3, {28'h0, ord[35:32]});
    wr(4'h4, 32'h1);
    seen = 1'h0;
    for (i = 1; i < 300; i++) begin
      @(posedge clk);
      reply_go <= rep && i == 12;
      #1;
      if (i == 5) chk(exec_stall, 1'h1);
      if (order_valid) seen = 1'h1;
      if (access_done) break;
    end
    if (i == 300) begin
      error_cnt++;
      complete_run();
    end
    chk(i, rep ? `PBS_MIN_CYC : `PBS_MAX_CYC);
    chk(exec_stall, 1'h0);
    chk(seen, nm == unit_name && cp == unit_copy);
    if (seen) begin
      chk(order_word, ord);
      chk(order_maint, mt);
      chk(order_parity_ok, 1'h1);
    end
    rd(4'h5, d);
    chk(d, rep ? 32'h6 : 32'hA);
    if (rep) begin
      rd(4'h6, d);
      chk(d, {8'h0, reply_with_data ? reply_data : 24'h00_0000});
    end
  endtask

  // Every control pulse polls one unit into its own reply bit
  task automatic polls();
    logic [31:0] d;
    wr(4'h0, 32'h0);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      poll_mask <= 8'h1 << j;
      poll_slot <= 5'(j * 3);
      poll_status <= 1'h1;
      wr(4'h4, 32'h100 << j);
      repeat (3) @(posedge clk);
      rd(4'h7, d);
      chk(d, 32'h1 << (j * 3));
    end
  endtask

  task automatic misc();
    logic [31:0] d;
    int n;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      flevel_in <= j == 0;
      interject_in <= j == 1;
      repeat (4) @(posedge clk);
      #1;
      chk({flevel_req, interject_req}, j == 0 ? 2'h2 : 2'h1);
    end
    @(posedge clk);
    interject_in <= 1'h0;
    wr(4'h0, 32'h3);
    rd(4'h0, d);
    chk(d, 32'h3);
    chk(bus.bus_copy_select, 1'h1);
    rd(4'h9, d);
    chk(d, 32'h0);
    rd(4'h4, d);
    chk(d, 32'h0);
    wr(4'h4, 32'h2);
    n = 0;
    repeat (4) begin
      #1;
      n += bus.order_write_bus[36];
      @(posedge clk);
    end
    chk(n, 1);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    access(12'h2C5, 1'h0, 1'h0, 1'h1);
    access(12'h2C5, 1'h1, 1'h0, 1'h1);
    @(posedge clk);
    reply_with_data <= 1'h0;
    access(12'h2C5, 1'h0, 1'h0, 1'h1);
    @(posedge clk);
    reply_with_data <= 1'h1;
    access(12'h2C4, 1'h0, 1'h0, 1'h0);
    access(12'h2C5, 1'h0, 1'h1, 1'h0);
    polls();
    misc();
    complete_run();
  end
endmodule // test_peripheral_bus_sequencer
